//--- rtl/updown_counter.sv
/*
 * 8-bit synchronous up/down counter with a shared three-state port,
 * pin controls, a cascade output and an ahb-lite register window.
 * assumes: pins come from outside hclk and are synchronised here; the
 * shared port wire is resolved outside from port_lines_oe_n.
 */
`timescale 1ns/1ns

module updown_counter
    import updown_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // control pins
    input wire logic mode_select_zero,
    input wire logic mode_select_one,
    input wire logic trickle_enable_n,
    input wire logic port_enable_n,
    // shared port lines as in, out and enable
    input wire logic [CNT_W-1:0] shared_port_lines_in,
    output logic [CNT_W-1:0] shared_port_lines_out,
    output logic [CNT_W-1:0] shared_port_lines_oe_n,
    // cascade output
    output logic terminal_count_n
);

    updown_core_if cif ();

    // pin synchroniser chain and the filtered pin view
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_ff;
    logic [PIN_W-1:0] sync2_ff;
    logic [PIN_W-1:0] sync3_ff;
    logic [PIN_W-1:0] pin_ff;
    logic [PIN_W-1:0] nxt_pin;

    // register state
    logic [CTRL_W-1:0] ctrl_ff;
    logic [CNT_W-1:0] load_ff;
    logic load_req_ff;
    logic [FLAG_W-1:0] flags_ff;
    logic [FLAG_W-1:0] nxt_flags;

    // bus data-phase state
    logic wr_pend_ff;
    logic [ADDR_W-1:0] wr_addr_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic take;

    // selected controls
    logic [1:0] mode_sel;
    logic enable_n_sel;
    logic oe_n_sel;
    logic oe_n_ff;

    // word offset within the register window
    function automatic logic [ADDR_W-1:0] word_ofs(input logic [31:0] a);
        word_ofs = {a[ADDR_W-1:2], 2'b00};
    endfunction

    // write strobe for one register, live in the cycle after the address phase
    function automatic logic wr_hit(
        input logic pend,
        input logic [ADDR_W-1:0] wa,
        input logic [ADDR_W-1:0] ofs
    );
        wr_hit = pend && wa == ofs;
    endfunction

    // status word assembled from live state
    function automatic logic [31:0] status_word(
        input logic [CNT_W-1:0] cnt,
        input logic tcn,
        input logic [1:0] m,
        input logic enn,
        input logic oen
    );
        logic [31:0] w;
        w = RDATA_ZERO;
        w[STAT_CNT_LSB +: CNT_W] = cnt;
        w[STAT_TC_N] = tcn;
        w[STAT_S0] = m[0];
        w[STAT_S1] = m[1];
        w[STAT_EN_N] = enn;
        w[STAT_OE_N] = oen;
        status_word = w;
    endfunction

    assign pin_raw = {port_enable_n, trickle_enable_n, mode_select_one, mode_select_zero, shared_port_lines_in};

    // reset leaves both selects low, so the count follows the port until the pins come through
    // three-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_ff <= PIN_RESET;
            sync2_ff <= PIN_RESET;
            sync3_ff <= PIN_RESET;
        end
        else
        begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a pin change counts only once stages two and three agree, bit by bit
    always_comb
    begin
        nxt_pin = pin_ff;
        for (int i = 0; i < PIN_W; i++)
        begin
            if (sync2_ff[i] == sync3_ff[i])
                nxt_pin[i] = sync3_ff[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pin_ff <= PIN_RESET;
        else
            pin_ff <= nxt_pin;
    end

    // software can take over the controls; pins rule by default
    // while software owns them the pins are still synchronised, only ignored
    always_comb
    begin
        if (ctrl_ff[CTRL_SW_OWN])
        begin
            mode_sel = {ctrl_ff[CTRL_S1], ctrl_ff[CTRL_S0]};
            enable_n_sel = ctrl_ff[CTRL_EN_N];
            oe_n_sel = ctrl_ff[CTRL_OE_N];
        end
        else
        begin
            mode_sel = {pin_ff[PIN_S1], pin_ff[PIN_S0]};
            enable_n_sel = pin_ff[PIN_EN_N];
            oe_n_sel = pin_ff[PIN_OE_N];
        end
    end

    // a software load command overrides for exactly one edge
    // the selected mode, from the pins or the control register, is back in charge at the next edge, whatever it says
    always_comb
    begin
        if (load_req_ff)
        begin
            cif.mode = MODE_LOAD;
            cif.load_data = load_ff;
        end
        else
        begin
            cif.mode = mode_sel;
            cif.load_data = pin_ff[PIN_DATA_LSB +: CNT_W];
        end
        cif.enable_n = enable_n_sel;
    end

    updown_core u_core (
        .hclk(hclk),
        .hresetn(hresetn),
        .cif(cif)
    );

    // port drivers; enable is registered so the port never glitches
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            oe_n_ff <= 1'b1;
        else
            oe_n_ff <= oe_n_sel;
    end

    assign shared_port_lines_out = cif.count;
    assign shared_port_lines_oe_n = {CNT_W{oe_n_ff}};

    // cascade output straight from the core's lookahead: a registered copy would fall
    // one edge late, once the count has already wrapped, and the next stage would step
    // one edge after this one wrapped; every input to it is a flip-flop, so it settles
    // early in the cycle and only the next stage's setup time limits the chain
    assign terminal_count_n = cif.tc_n;

    // ahb-lite: zero wait states, always okay
    // size is not checked: every register is one aligned word
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign take = hsel && hready && htrans[HTRANS_ACTIVE_BIT];

    // capture write address phase; the data follows in the next cycle
    // the address is captured every cycle; only wr_pend_ff says whether it matters
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= OFS_CTRL;
        end
        else
        begin
            wr_pend_ff <= take && hwrite;
            wr_addr_ff <= word_ofs(haddr);
        end
    end

    // control register write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_ff <= CTRL_RESET;
        else if (wr_hit(wr_pend_ff, wr_addr_ff, OFS_CTRL))
            ctrl_ff <= hwdata[CTRL_W-1:0];
    end

    // load register write also requests one load edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            load_ff <= CNT_ZERO;
            load_req_ff <= 1'b0;
        end
        else
        begin
            load_req_ff <= wr_hit(wr_pend_ff, wr_addr_ff, OFS_LOAD);
            if (wr_hit(wr_pend_ff, wr_addr_ff, OFS_LOAD))
                load_ff <= hwdata[CNT_W-1:0];
        end
    end

    // sticky wrap flags: a wrap in the clearing cycle survives the clear
    always_comb
    begin
        nxt_flags = flags_ff;
        if (wr_hit(wr_pend_ff, wr_addr_ff, OFS_FLAGS))
            nxt_flags = flags_ff & ~hwdata[FLAG_W-1:0];
        if (cif.wrap_up)
            nxt_flags[FLAG_WRAP_UP] = 1'b1;
        if (cif.wrap_down)
            nxt_flags[FLAG_WRAP_DOWN] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flags_ff <= FLAG_RESET;
        else
            flags_ff <= nxt_flags;
    end

    // read data picked at the address phase and held through the data phase
    // only address bits [3:2] pick a register; any higher bit set reads as zero
    always_comb
    begin
        nxt_rdata = RDATA_ZERO;
        case (word_ofs(haddr))
            OFS_CTRL: nxt_rdata[CTRL_W-1:0] = ctrl_ff;
            OFS_LOAD: nxt_rdata[CNT_W-1:0] = load_ff;
            OFS_STATUS: nxt_rdata = status_word(cif.count, cif.tc_n, cif.mode, cif.enable_n, oe_n_ff);
            OFS_FLAGS: nxt_rdata[FLAG_W-1:0] = flags_ff;
            default: nxt_rdata = RDATA_ZERO;
        endcase
        if (haddr[31:ADDR_W] != '0)
            nxt_rdata = RDATA_ZERO;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_ff <= RDATA_ZERO;
        else if (take && !hwrite)
            rdata_ff <= nxt_rdata;
    end

    assign hrdata = rdata_ff;

endmodule

//--- rtl/updown_pkg.sv
/*
 * shared constants and types for the 8-bit up/down counter block:
 * register offsets, field positions, reset values and the mode encoding.
 * assumes: one clock (hclk), 32-bit ahb-lite data, word-aligned registers.
 */
package updown_pkg;

    // counter geometry
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

    // pin synchroniser depth and width of the synchronised pin bundle
    localparam int SYNC_STAGES = 3;
    localparam int PIN_W = 12;
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_S0 = 8;
    localparam int PIN_S1 = 9;
    localparam int PIN_EN_N = 10;
    localparam int PIN_OE_N = 11;
    localparam logic [PIN_W-1:0] PIN_RESET = 12'hc00;

    // register byte offsets
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LOAD = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'hc;

    // control register fields
    localparam int CTRL_SW_OWN = 0;
    localparam int CTRL_S0 = 1;
    localparam int CTRL_S1 = 2;
    localparam int CTRL_EN_N = 3;
    localparam int CTRL_OE_N = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h18;

    // status register fields
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_TC_N = 8;
    localparam int STAT_S0 = 9;
    localparam int STAT_S1 = 10;
    localparam int STAT_EN_N = 11;
    localparam int STAT_OE_N = 12;

    // sticky flag register fields, write one to clear
    localparam int FLAG_WRAP_UP = 0;
    localparam int FLAG_WRAP_DOWN = 1;
    localparam int FLAG_W = 2;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 2'h0;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;

    // operating mode as {select one, select zero}
    typedef enum logic [1:0] {
        MODE_LOAD = 2'b00,
        MODE_DOWN = 2'b01,
        MODE_BOTH = 2'b11,
        MODE_UP = 2'b10
    } mode_t;

endpackage

//--- rtl/updown_core_if.sv
/*
 * carrier between the register/pin front end and the counting core.
 * assumes: both ends run on hclk; the core owns count and terminal count.
 */
`timescale 1ns/1ns
interface updown_core_if;
    import updown_pkg::*;

    logic [1:0] mode;
    logic enable_n;
    logic [CNT_W-1:0] load_data;
    logic [CNT_W-1:0] count;
    logic tc_n;
    logic wrap_up;
    logic wrap_down;

    modport core (
        input mode,
        input enable_n,
        input load_data,
        output count,
        output tc_n,
        output wrap_up,
        output wrap_down
    );

    modport ctl (
        output mode,
        output enable_n,
        output load_data,
        input count,
        input tc_n,
        input wrap_up,
        input wrap_down
    );
endinterface

//--- rtl/updown_core.sv
/*
 * the counting core: eight flip-flops that load, hold, count up or down.
 * assumes: mode, enable and load data are already synchronous to hclk.
 */
`timescale 1ns/1ns
module updown_core
    import updown_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control and results
    updown_core_if.core cif
);

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic at_boundary;

    // counting happens only when the trickle enable is active
    function automatic logic counting(input logic [1:0] m, input logic en_n);
        counting = !en_n && (m == MODE_UP || m == MODE_DOWN);
    endfunction

    // next count per mode; both selects high is illegal and simply holds
    always_comb
    begin
        nxt_count = count_ff;
        case (cif.mode)
            MODE_LOAD: nxt_count = cif.load_data;
            MODE_UP:
            begin
                if (!cif.enable_n)
                    nxt_count = count_ff + CNT_ONE;
            end
            MODE_DOWN:
            begin
                if (!cif.enable_n)
                    nxt_count = count_ff - CNT_ONE;
            end
            default: nxt_count = count_ff;
        endcase
        if (cif.mode != MODE_LOAD && cif.enable_n)
            nxt_count = count_ff;
    end

    // state changes on the rising edge only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count_ff <= CNT_ZERO;
        else
            count_ff <= nxt_count;
    end

    // boundary depends on direction: all ones going up, all zeros going down
    always_comb
    begin
        at_boundary = (cif.mode == MODE_UP && count_ff == CNT_MAX)
            || (cif.mode == MODE_DOWN && count_ff == CNT_ZERO);
    end

    // carry lookahead for the next stage, high whenever not counting
    assign cif.tc_n = !(counting(cif.mode, cif.enable_n) && at_boundary);
    assign cif.count = count_ff;
    assign cif.wrap_up = counting(cif.mode, cif.enable_n) && cif.mode == MODE_UP && at_boundary;
    assign cif.wrap_down = counting(cif.mode, cif.enable_n) && cif.mode == MODE_DOWN && at_boundary;

endmodule

//--- verif/updown_counter_checker.sv
/* port assertions for the up/down counter.
   assumes: bound to updown_counter; the pin path lags several edges, so
   pin relations are judged only once pins and bus have been quiet. */
`timescale 1ns/1ns
module updown_counter_checker
    import updown_pkg::*;
(
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hreadyout,
    input wire logic hresp,
    // pins
    input wire logic mode_select_zero,
    input wire logic mode_select_one,
    input wire logic trickle_enable_n,
    input wire logic port_enable_n,
    input wire logic [CNT_W-1:0] shared_port_lines_in,
    input wire logic [CNT_W-1:0] shared_port_lines_out,
    input wire logic [CNT_W-1:0] shared_port_lines_oe_n,
    input wire logic terminal_count_n
);
    localparam logic [3:0] SETTLE = 4'h8;
    logic [1:0] mode;
    logic [11:0] pins;
    logic [11:0] pins_ff;
    logic [3:0] quiet_ff;
    logic calm;

    // port data only matters while loading; counting on a driven port must not look like a pin change
    assign mode = {mode_select_one, mode_select_zero};
    assign pins = {port_enable_n, trickle_enable_n, mode, (mode == MODE_LOAD) ? shared_port_lines_in : 8'h00};
    // the quiet count lags the pins by one edge, so the edge at which a pin or a bus
    // request moves is not calm either
    assign calm = quiet_ff >= SETTLE && pins == pins_ff && !(hsel && htrans[1]);

    // edges since the pins last moved or a bus transfer was taken
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pins_ff <= 12'h000;
            quiet_ff <= 4'h0;
        end
        else
        begin
            pins_ff <= pins;
            if (pins != pins_ff || (hsel && htrans[1]))
                quiet_ff <= 4'h0;
            else if (quiet_ff != 4'hf)
                quiet_ff <= quiet_ff + 4'h1;
        end
    end

    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_up_top;
        calm && mode == MODE_UP && !trickle_enable_n && shared_port_lines_out == CNT_MAX;
    endsequence
    sequence s_down_bottom;
        calm && mode == MODE_DOWN && !trickle_enable_n && shared_port_lines_out == CNT_ZERO;
    endsequence

    a_bus_answer_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready and okay");
    a_oe_lines_agree: assert property (shared_port_lines_oe_n == 8'h00 || shared_port_lines_oe_n == 8'hff)
        else $error("port enables disagree");
    a_oe_follows_pin: assert property (calm |-> shared_port_lines_oe_n == {CNT_W{port_enable_n}})
        else $error("port enable does not follow pin");
    a_load_from_port: assert property (calm && mode == MODE_LOAD |-> shared_port_lines_out == shared_port_lines_in)
        else $error("load did not take port value");
    a_hold_keeps_count: assert property (calm && mode != MODE_LOAD && (trickle_enable_n || mode == MODE_BOTH)
        |=> $stable(shared_port_lines_out) && terminal_count_n)
        else $error("hold changed count or terminal count");
    a_count_up_step: assert property (calm && mode == MODE_UP && !trickle_enable_n
        |=> shared_port_lines_out == $past(shared_port_lines_out) + CNT_ONE)
        else $error("count up step wrong");
    a_count_down_step: assert property (calm && mode == MODE_DOWN && !trickle_enable_n
        |=> shared_port_lines_out == $past(shared_port_lines_out) - CNT_ONE)
        else $error("count down step wrong");
    a_tc_only_boundary: assert property (!terminal_count_n
        |-> shared_port_lines_out == CNT_MAX || shared_port_lines_out == CNT_ZERO)
        else $error("terminal count away from boundary");
    a_tc_low_wraps: assert property (s_up_top or s_down_bottom |-> !terminal_count_n)
        else $error("terminal count missing at boundary");
endmodule

bind updown_counter updown_counter_checker updown_counter_checker_i (.hclk, .hresetn, .hsel, .htrans,
    .hreadyout, .hresp, .mode_select_zero, .mode_select_one, .trickle_enable_n, .port_enable_n,
    .shared_port_lines_in, .shared_port_lines_out, .shared_port_lines_oe_n, .terminal_count_n);

//--- verif/port_bus_model.sv
/* system data bus on the shared port lines.
   assumes: the bench says when the bus drives; the counter wins where its enable is low. */
`timescale 1ns/1ns
module port_bus_model
    import updown_pkg::*;
(
    // clock
    input wire logic hclk,
    // far-side drive request
    input wire logic drive_en,
    input wire logic [CNT_W-1:0] drive_data,
    // counter side
    input wire logic [CNT_W-1:0] dev_out,
    input wire logic [CNT_W-1:0] dev_oe_n,
    // resolved wire
    output logic [CNT_W-1:0] wire_level
);
    logic [CNT_W-1:0] last_ff = 8'h00;

    // no pull on these lines: a released line shows the inverse of its last driven level
    always_comb
    begin
        wire_level = ~last_ff;
        for (int i = 0; i < CNT_W; i++)
        begin
            if (!dev_oe_n[i])
                wire_level[i] = dev_out[i];
            else if (drive_en)
                wire_level[i] = drive_data[i];
        end
    end

    // remember only driven levels so a floating line stays put
    always @(posedge hclk)
    begin
        if (drive_en || dev_oe_n != 8'hff)
            last_ff <= wire_level;
    end
endmodule

//--- verif/eight_bit_updown_counter_bench.sv
/* self-checking bench for the up/down counter, one task per scenario.
   assumes: zero-wait bus answers; pin changes act within eight edges. */
`timescale 1ns/1ns
module eight_bit_updown_counter_bench;
    import updown_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic mode_select_zero = 1'b1;
    logic mode_select_one = 1'b1;
    logic trickle_enable_n = 1'b1;
    logic port_enable_n = 1'b1;
    logic drive_en = 1'b0;
    logic [CNT_W-1:0] drive_data = 8'h00;
    logic [CNT_W-1:0] shared_port_lines_in;
    logic [CNT_W-1:0] shared_port_lines_out;
    logic [CNT_W-1:0] shared_port_lines_oe_n;
    logic terminal_count_n;
    int err_count = 0;
    int compares = 0;

    updown_counter updown_counter_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .mode_select_zero, .mode_select_one,
        .trickle_enable_n, .port_enable_n, .shared_port_lines_in, .shared_port_lines_out,
        .shared_port_lines_oe_n, .terminal_count_n);
    port_bus_model port_bus_model_i (.hclk, .drive_en, .drive_data, .dev_out(shared_port_lines_out),
        .dev_oe_n(shared_port_lines_oe_n), .wire_level(shared_port_lines_in));

    always #50 hclk = ~hclk;

    task automatic final_report();
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge hclk);
        #1;
    endtask

    // one single transfer; address phase held until ready, read data taken at the data-phase edge
    task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    // pins are levels; give the synchroniser time to settle before judging
    task automatic set_pins(input logic [1:0] m, input logic en_n, input logic oe_n);
        @(posedge hclk);
        mode_select_one <= m[1];
        mode_select_zero <= m[0];
        trickle_enable_n <= en_n;
        port_enable_n <= oe_n;
        repeat (8) @(posedge hclk);
        #1;
    endtask

    task automatic t_reset();
        logic [31:0] rd;
        check("oe after reset", 32'hff, {24'h0, shared_port_lines_oe_n});
        check("tc after reset", 32'h1, {31'h0, terminal_count_n});
        bus_xfer(1'b0, {28'h0, OFS_CTRL}, 32'h0, rd);
        check("ctrl reset", {27'h0, CTRL_RESET}, rd);
        bus_xfer(1'b0, 32'h10, 32'h0, rd);
        check("unmapped read", RDATA_ZERO, rd);
    endtask

    task automatic t_load(input logic [CNT_W-1:0] v);
        @(posedge hclk);
        drive_data <= v;
        drive_en <= 1'b1;
        set_pins(MODE_LOAD, 1'b0, 1'b1);
        check("loaded count", {24'h0, v}, {24'h0, shared_port_lines_out});
        check("oe while loading", 32'hff, {24'h0, shared_port_lines_oe_n});
        set_pins(MODE_UP, 1'b1, 1'b1);
        check("held load", {24'h0, v}, {24'h0, shared_port_lines_out});
        @(posedge hclk);
        drive_en <= 1'b0;
    endtask

    task automatic t_count_up();
        logic [CNT_W-1:0] v;
        set_pins(MODE_UP, 1'b0, 1'b1);
        for (int i = 0; i < 40 && shared_port_lines_out !== CNT_MAX; i++)
            tick();
        check("tc at top", 32'h0, {31'h0, terminal_count_n});
        tick();
        v = shared_port_lines_out;
        check("count after wrap", 32'h0, {24'h0, v});
        check("tc after wrap", 32'h1, {31'h0, terminal_count_n});
        @(negedge hclk);
        check("falling edge count", {24'h0, v}, {24'h0, shared_port_lines_out});
    endtask

    task automatic t_hold(input logic [1:0] m, input logic en_n);
        logic [CNT_W-1:0] v;
        set_pins(m, en_n, 1'b1);
        v = shared_port_lines_out;
        repeat (4) tick();
        check("held count", {24'h0, v}, {24'h0, shared_port_lines_out});
        check("tc while held", 32'h1, {31'h0, terminal_count_n});
    endtask

    task automatic t_down();
        logic [31:0] rd;
        bus_xfer(1'b1, {28'h0, OFS_LOAD}, 32'h08, rd);
        tick();
        bus_xfer(1'b0, {28'h0, OFS_STATUS}, 32'h0, rd);
        check("status count", 32'h08, {24'h0, rd[7:0]});
        set_pins(MODE_DOWN, 1'b0, 1'b1);
        for (int i = 0; i < 40 && shared_port_lines_out !== CNT_ZERO; i++)
            tick();
        check("tc at bottom", 32'h0, {31'h0, terminal_count_n});
        tick();
        check("count after borrow", 32'hff, {24'h0, shared_port_lines_out});
        bus_xfer(1'b0, {28'h0, OFS_FLAGS}, 32'h0, rd);
        check("wrap flags", 32'h3, rd);
        bus_xfer(1'b1, {28'h0, OFS_FLAGS}, 32'h3, rd);
        bus_xfer(1'b0, {28'h0, OFS_FLAGS}, 32'h0, rd);
        check("flags cleared", 32'h0, rd);
    endtask

    // software takes the controls over from the pins, then hands them back
    task automatic t_soft();
        logic [31:0] rd;
        set_pins(MODE_BOTH, 1'b0, 1'b1);
        bus_xfer(1'b1, {28'h0, OFS_LOAD}, 32'h40, rd);
        bus_xfer(1'b1, {28'h0, OFS_CTRL}, 32'h13, rd);
        bus_xfer(1'b0, {28'h0, OFS_STATUS}, 32'h0, rd);
        check("soft down status", 32'h133f, rd);
        bus_xfer(1'b1, {28'h0, OFS_CTRL}, {27'h0, CTRL_RESET}, rd);
    endtask

    task automatic t_drive();
        logic [31:0] rd;
        set_pins(MODE_UP, 1'b1, 1'b0);
        check("oe when enabled", 32'h0, {24'h0, shared_port_lines_oe_n});
        bus_xfer(1'b1, {28'h0, OFS_LOAD}, 32'h5a, rd);
        tick();
        check("port shows count", 32'h5a, {24'h0, shared_port_lines_in});
        set_pins(MODE_UP, 1'b1, 1'b1);
        check("oe when disabled", 32'hff, {24'h0, shared_port_lines_oe_n});
    endtask

    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_load(8'hf0);
        t_count_up();
        t_hold(MODE_UP, 1'b1);
        t_hold(MODE_BOTH, 1'b0);
        t_down();
        t_soft();
        t_drive();
        final_report();
    end

    // cut a hang short
    initial
    begin
        #200000;
        err_count++;
        final_report();
    end
endmodule
